// ### bfu_breaker_failure.sv
// breaker failure supervision with wishbone register slave
`timescale 1ns/1ps
// Contract
// - scheme selects current, position or both
// - current scheme: fail if current stays high
// - position scheme: fail if not shown open
// - combined: fail needs current and closed
// - off frequency: current blocked, combined as position
// - timer keeps running after trigger drops
// - expiry without stop gives backup trip
// - opening per scheme stops the timer
// - opening with triggers active enters rejected
// - rejected returns standby when triggers drop
// - lockout latched with trip until acknowledge
// - three extra trigger inputs start supervision
// - trigger mode filters assigned trip commands
// - threshold and time from four sets
// - side select picks neutral or mains currents
module bfu_breaker_failure #(
  parameter int TICK_CYCLES = bfu_pkg::TICK_CYC
) (
  input  wire logic                                 CLK_I,
  input  wire logic                                 RESET_N_I,
  input  wire logic                                 CYC_I,
  input  wire logic                                 STB_I,
  input  wire logic                                 WE_I,
  input  wire logic [7:0]                           ADR_I,
  input  wire logic [3:0]                           SEL_I,
  input  wire logic [31:0]                          DAT_I,
  output logic      [31:0]                          DAT_O,
  output logic                                      ACK_O,
  input  wire logic [bfu_pkg::PHASES*bfu_pkg::CUR_W-1:0] NEUTRAL_CUR_I,
  input  wire logic [bfu_pkg::PHASES*bfu_pkg::CUR_W-1:0] MAINS_CUR_I,
  input  wire logic                                 POS_OPEN_I,
  input  wire logic                                 FREQ_DEV_I,
  input  wire logic                                 TRIP_EXT_I,
  input  wire logic                                 TRIP_CUR_I,
  input  wire logic                                 TRIP_OTHER_I,
  input  wire logic [bfu_pkg::XTRIG-1:0]            XTRIG_I,
  output logic                                      BACKUP_TRIP_O,
  output logic                                      LOCKOUT_O,
  output logic                                      REJECTED_O,
  output logic                                      IRQ_O
);
  import bfu_pkg::*;

  logic [7:0]       ctrl_q;
  logic [IRQ_W-1:0] irq_q;
  logic [IRQ_W-1:0] mask_q;
  logic [CUR_W-1:0] thr_q [SETS];
  logic [TMR_W-1:0] tim_q [SETS];
  logic [6:0]       pin_s1_q;
  logic [6:0]       pin_s2_q;
  logic [TICK_W-1:0] pre_q;
  logic [TMR_W-1:0] cnt_q;
  logic             lock_q;
  bfu_state_e       st_q;

  logic             bus_req;
  logic             wr;
  logic             wr_acc;
  logic             ack_set;
  logic [1:0]       scheme;
  logic [1:0]       tmode;
  logic [1:0]       pset;
  logic             pos_open;
  logic             freq_dev;
  logic             t_ext;
  logic             t_cur;
  logic             t_oth;
  logic [XTRIG-1:0] xtrig;
  logic             trig;
  logic             cur_low;
  logic             opened;
  logic             tick;
  logic             expire;
  logic [PHASES-1:0] ph_low;

  assign bus_req = CYC_I & STB_I & ~ACK_O;
  // writes land on the ack edge, while the master is known to still hold the request
  assign wr_acc  = CYC_I & STB_I & ACK_O & WE_I;
  assign wr      = wr_acc & SEL_I[0];
  assign ack_set = wr & (ADR_I == A_CTRL) & DAT_I[C_ACK];
  assign scheme  = ctrl_q[C_SCH+1:C_SCH];
  assign tmode   = ctrl_q[C_TRG+1:C_TRG];
  assign pset    = ctrl_q[C_SET+1:C_SET];

  // field pins are asynchronous: two stages before use
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      pin_s1_q <= {XTRIG_I, TRIP_OTHER_I, TRIP_CUR_I, TRIP_EXT_I, FREQ_DEV_I};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic pos_s1_q;
  logic pos_s2_q;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
    end else begin
      pos_s1_q <= POS_OPEN_I;
      pos_s2_q <= pos_s1_q;
    end
  end
  assign pos_open = pos_s2_q;
  assign freq_dev = pin_s2_q[0];
  assign t_ext    = pin_s2_q[1];
  assign t_cur    = pin_s2_q[2];
  assign t_oth    = pin_s2_q[3];
  assign xtrig    = pin_s2_q[6:4];

  // trigger mode filter plus the always-live extra inputs
  always_comb begin
    case (tmode)
      TRG_ALL:  trig = t_ext | t_cur | t_oth;
      TRG_EXT:  trig = t_ext;
      TRG_CUR:  trig = t_cur;
      default:  trig = 1'b0;
    endcase
    trig = trig | (|xtrig);
  end

  // current samples are taken as already synchronous to the clock
  generate
    for (genvar p = 0; p < PHASES; p++) begin : g_ph
      logic [CUR_W-1:0] mag;
      assign mag = ctrl_q[C_SIDE] ? MAINS_CUR_I[p*CUR_W +: CUR_W]
                                  : NEUTRAL_CUR_I[p*CUR_W +: CUR_W];
      assign ph_low[p] = mag < thr_q[pset];
    end
  endgenerate
  assign cur_low = &ph_low;

  // off-nominal frequency makes current evidence untrustworthy
  always_comb begin
    case (scheme)
      SCH_CUR:  opened = freq_dev ? 1'b0 : cur_low;
      SCH_POS:  opened = pos_open;
      SCH_BOTH: opened = freq_dev ? pos_open : (cur_low | pos_open);
      default:  opened = pos_open;
    endcase
  end

  assign tick   = (pre_q == TICK_W'(TICK_CYCLES - 1));
  assign expire = tick & (cnt_q >= tim_q[pset]);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      pre_q <= '0;
    else if (st_q != ST_RUN || tick)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      cnt_q <= '0;
    else if (st_q != ST_RUN)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q <= ST_STANDBY;
    end else begin
      case (st_q)
        ST_STANDBY: if (trig) st_q <= ST_RUN;
        ST_RUN: begin
          if (opened)
            st_q <= trig ? ST_REJECT : ST_STANDBY;
          else if (expire)
            st_q <= ST_TRIP;
        end
        ST_REJECT: if (!trig) st_q <= ST_STANDBY;
        ST_TRIP:   if (!trig && !lock_q) st_q <= ST_STANDBY;
        default:   st_q <= ST_STANDBY;
      endcase
    end
  end

  // lockout outlives trigger; only software acknowledge clears it
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      lock_q <= 1'b0;
    else if (st_q == ST_RUN && !opened && expire)
      lock_q <= 1'b1;
    else if (ack_set)
      lock_q <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      BACKUP_TRIP_O <= 1'b0;
      LOCKOUT_O     <= 1'b0;
      REJECTED_O    <= 1'b0;
      IRQ_O         <= 1'b0;
    end else begin
      BACKUP_TRIP_O <= (st_q == ST_TRIP);
      LOCKOUT_O     <= lock_q;
      REJECTED_O    <= (st_q == ST_REJECT);
      IRQ_O         <= |(irq_q & mask_q);
    end
  end

  // sticky events; a new event wins over a write-one clear
  logic [IRQ_W-1:0] ev;
  assign ev[I_TRIP]  = (st_q == ST_RUN) & ~opened & expire;
  assign ev[I_REJ]   = (st_q == ST_RUN) & opened & trig;
  assign ev[I_START] = (st_q == ST_STANDBY) & trig;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      irq_q <= '0;
    else if (wr && ADR_I == A_IRQ)
      irq_q <= (irq_q & ~DAT_I[IRQ_W-1:0]) | ev;
    else
      irq_q <= irq_q | ev;
  end

  // software owns scheme, trigger mode, side, set and limits
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= 8'h00;
      mask_q <= '0;
      for (int s = 0; s < SETS; s++) begin
        thr_q[s] <= THR_RST;
        tim_q[s] <= TIM_RST;
      end
    end else if (wr_acc) begin
      if (ADR_I == A_CTRL && SEL_I[0])
        ctrl_q <= {1'b0, DAT_I[6:0]};
      if (ADR_I == A_MASK && SEL_I[0])
        mask_q <= DAT_I[IRQ_W-1:0];
      for (int s = 0; s < SETS; s++) begin
        if (ADR_I == A_THR0 + 8'(4 * s) && SEL_I[1:0] == 2'h3)
          thr_q[s] <= DAT_I[CUR_W-1:0];
        if (ADR_I == A_TIM0 + 8'(4 * s) && SEL_I[2:0] == 3'h7)
          tim_q[s] <= DAT_I[TMR_W-1:0];
      end
    end
  end

  // one wait state answer; unmapped reads return zero
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= '0;
      if (bus_req && !WE_I) begin
        if (ADR_I == A_CTRL)
          DAT_O <= {24'h0, lock_q, ctrl_q[6:0]};
        else if (ADR_I == A_STAT)
          DAT_O <= {24'h0, cur_low, pos_open, freq_dev, trig, st_q};
        else if (ADR_I == A_IRQ)
          DAT_O <= {29'h0, irq_q};
        else if (ADR_I == A_MASK)
          DAT_O <= {29'h0, mask_q};
        for (int s = 0; s < SETS; s++) begin
          if (ADR_I == A_THR0 + 8'(4 * s))
            DAT_O <= {16'h0, thr_q[s]};
          if (ADR_I == A_TIM0 + 8'(4 * s))
            DAT_O <= {8'h0, tim_q[s]};
        end
      end
    end
  end

  chk_trip_after_expire: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    ev[I_TRIP] |=> ##1 BACKUP_TRIP_O && LOCKOUT_O)
    else $error("no backup trip after expiry");
  chk_lock_holds: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    lock_q && !ack_set |=> lock_q)
    else $error("lockout dropped without acknowledge");
  chk_reject_exit: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_REJECT && !trig |=> st_q == ST_STANDBY)
    else $error("rejected did not return to standby");
  chk_reject_entry: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_RUN && opened && trig |=> st_q == ST_REJECT)
    else $error("opening with trigger not rejected");
  chk_run_holds: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_RUN && !opened && !expire && !trig |=> st_q == ST_RUN)
    else $error("timer stopped on trigger drop");
  chk_stop_open: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_RUN && opened |=> st_q != ST_RUN && st_q != ST_TRIP)
    else $error("timer not stopped on opening");
  chk_freq_block: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    freq_dev && scheme == SCH_CUR |-> !opened)
    else $error("current scheme not blocked off frequency");
  chk_no_restart: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_REJECT |=> st_q != ST_RUN)
    else $error("restart from rejected state");
  chk_ack_single: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  chk_start_run: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_STANDBY && trig |=> st_q == ST_RUN)
    else $error("trigger in standby did not start supervision");
  chk_cur_open: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    scheme == SCH_CUR && !freq_dev && cur_low |-> opened)
    else $error("low current not seen as opening");
  chk_pos_open: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    scheme == SCH_POS |-> opened == pos_open)
    else $error("position scheme ignores indicators");
  chk_both_closed: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    scheme == SCH_BOTH && !cur_low && !pos_open |-> !opened)
    else $error("combined scheme opened with both closed");
  chk_both_open: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    scheme == SCH_BOTH && !freq_dev && (cur_low || pos_open) |-> opened)
    else $error("combined scheme missed an opening");
  chk_freq_pos: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    freq_dev && scheme == SCH_BOTH |-> opened == pos_open)
    else $error("combined scheme not position only off frequency");
  chk_expire_trip: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_RUN && !opened && expire |=> st_q == ST_TRIP)
    else $error("expiry did not enter trip");
  chk_trip_held: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_TRIP && (trig || lock_q) |=> st_q == ST_TRIP)
    else $error("trip state left too early");
  chk_lock_ack: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    lock_q && ack_set && !ev[I_TRIP] |=> !lock_q)
    else $error("acknowledge did not clear lockout");
  chk_irq_set: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    ev[I_TRIP] |=> irq_q[I_TRIP])
    else $error("trip event not recorded");
  chk_irq_level: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    |(irq_q & mask_q) |=> IRQ_O)
    else $error("interrupt output missing");
  chk_reject_out: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q == ST_REJECT |=> REJECTED_O)
    else $error("rejected output missing");
  chk_cnt_idle: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    st_q != ST_RUN |=> cnt_q == '0)
    else $error("timer not cleared outside supervision");
endmodule

// ### bfu_breaker_model.sv
// breaker model: position contact and phase currents on both sensor sides
`timescale 1ns/1ps
module bfu_breaker_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        open_cmd_i,
  input  wire logic        cur_stuck_i,
  input  wire logic        pos_stuck_i,
  output logic             pos_open_o,
  output logic [47:0]      neutral_cur_o,
  output logic [47:0]      mains_cur_o
);
  localparam logic [15:0] LOAD  = 16'h0800;
  // stuck level equals the bench threshold: at threshold is not below
  localparam logic [15:0] STUCK = 16'h0200;
  logic [2:0] dly_q;
  // contacts part a few cycles after the command, like a real mechanism
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_q <= 3'h0;
    end else if (!open_cmd_i) begin
      dly_q <= 3'h0;
    end else if (dly_q != 3'h5) begin
      dly_q <= dly_q + 3'h1;
    end
  end
  assign pos_open_o    = (dly_q == 3'h5) && !pos_stuck_i;
  // neutral side keeps feeding current after opening; only top phase sticks
  assign neutral_cur_o = {3{LOAD}};
  assign mains_cur_o   = (dly_q != 3'h5) ? {3{LOAD}} : (cur_stuck_i ? {STUCK, 32'h0} : 48'h0);
endmodule

// ### bfu_pkg.sv
// package: breaker failure unit constants and types
package bfu_pkg;
  localparam int          PHASES     = 3;
  localparam int          CUR_W      = 16;
  localparam int          SETS       = 4;
  localparam int          XTRIG      = 3;
  localparam int          TMR_W      = 24;
  localparam int          CLK_HZ     = 40000000;
  localparam int          TICK_US    = 1000;
  localparam int          TICK_CYC   = (CLK_HZ / 1000000) * TICK_US;
  localparam int          TICK_W     = 16;
  // register byte addresses
  localparam logic [7:0]  A_CTRL     = 8'h00;
  localparam logic [7:0]  A_STAT     = 8'h04;
  localparam logic [7:0]  A_IRQ      = 8'h08;
  localparam logic [7:0]  A_MASK     = 8'h0C;
  localparam logic [7:0]  A_THR0     = 8'h10;
  localparam logic [7:0]  A_TIM0     = 8'h20;
  // control field positions
  localparam int          C_SCH      = 0;
  localparam int          C_TRG      = 2;
  localparam int          C_SIDE     = 4;
  localparam int          C_SET      = 5;
  localparam int          C_ACK      = 7;
  localparam logic [1:0]  SCH_CUR    = 2'h0;
  localparam logic [1:0]  SCH_POS    = 2'h1;
  localparam logic [1:0]  SCH_BOTH   = 2'h2;
  localparam logic [1:0]  TRG_ALL    = 2'h0;
  localparam logic [1:0]  TRG_EXT    = 2'h1;
  localparam logic [1:0]  TRG_CUR    = 2'h2;
  localparam logic [1:0]  TRG_NONE   = 2'h3;
  // interrupt bits
  localparam int          IRQ_W      = 3;
  localparam int          I_TRIP     = 0;
  localparam int          I_REJ      = 1;
  localparam int          I_START    = 2;
  localparam logic [CUR_W-1:0] THR_RST = 16'h0100;
  localparam logic [TMR_W-1:0] TIM_RST = 24'h000096;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_RUN     = 4'h2,
    ST_REJECT  = 4'h4,
    ST_TRIP    = 4'h8
  } bfu_state_e;
endpackage

// ### tb.sv
// self-checking bench for the breaker failure unit
`timescale 1ns/1ps
module tb;
  import bfu_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic [47:0] ncur, mcur;
  logic [5:0]  trg = 0;
  logic        pos, fd = 0, bkp, lock, rej, irq;
  logic        open_cmd = 0, cur_stk = 0, pos_stk = 0;
  int          fails = 0, comparisons = 0;

  initial forever #12.5 clk = ~clk;

  bfu_breaker_failure #(.TICK_CYCLES(4)) u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .NEUTRAL_CUR_I(ncur),
    .MAINS_CUR_I(mcur), .POS_OPEN_I(pos), .FREQ_DEV_I(fd), .TRIP_EXT_I(trg[0]), .TRIP_CUR_I(trg[1]),
    .TRIP_OTHER_I(trg[2]), .XTRIG_I(trg[5:3]), .BACKUP_TRIP_O(bkp), .LOCKOUT_O(lock), .REJECTED_O(rej),
    .IRQ_O(irq));
  bfu_breaker_model u_brk (.clk_i(clk), .rst_n_i(rst_n), .open_cmd_i(open_cmd), .cur_stuck_i(cur_stk),
    .pos_stuck_i(pos_stk), .pos_open_o(pos), .neutral_cur_o(ncur), .mains_cur_o(mcur));

  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        report_and_stop();
      end
      @(posedge clk);
    end
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  function automatic logic starts(int md, int src);
    if (src > 2 || md == 0) return 1;
    return (md == 1 && src == 0) || (md == 2 && src == 1);
  endfunction
  // breaker failure expected when opening is not proven under the scheme
  function automatic logic exp_trip(int sch, int kind, int f, int side);
    logic cl, po;
    cl = side && !kind[0] && !f;
    po = !kind[1];
    if (sch == 0) return !cl;
    if (sch == 1) return !po;
    return !(f ? po : (cl || po));
  endfunction

  initial begin
    logic [31:0] r, ctrl;
    int sch, kind, fv, side, set, m, src;
    logic e;
    void'($urandom(18826));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    check(32'({bkp, lock, rej, irq}), 0);
    wb(0, A_THR0, 0, r); check(r, 32'(THR_RST));
    wb(0, A_TIM0, 0, r); check(r, 32'(TIM_RST));
    wb(1, 8'h40, 32'hFFFF, r);
    wb(0, 8'h40, 0, r); check(r, 0);
    for (int s = 0; s < SETS; s++) begin
      wb(1, A_THR0 + 8'(4 * s), 32'h0200, r);
      wb(1, A_TIM0 + 8'(4 * s), 32'(4 + s), r);
      wb(0, A_TIM0 + 8'(4 * s), 0, r); check(r, 32'(4 + s));
    end
    // breaker held open so each start ends at once
    open_cmd <= 1;
    wb(1, A_MASK, 0, r);
    for (int md = 0; md < 4; md++) begin
      for (int sr = 0; sr < 6; sr++) begin
        wb(1, A_CTRL, 32'(1 | md << 2 | 1 << 4), r);
        wb(1, A_IRQ, 32'h7, r);
        trg <= 6'(1 << sr);
        repeat (3) @(posedge clk);
        trg <= 0;
        repeat (10) @(posedge clk);
        wb(0, A_IRQ, 0, r); check(32'(r[I_START]), 32'(starts(md, sr)));
      end
    end
    for (int n = 0; n < 48; n++) begin
      sch = n % 3; kind = (n / 3) % 4; fv = (n / 12) % 2; side = n / 24;
      set = $urandom % 4; m = $urandom % 2; src = $urandom % 6;
      ctrl = 32'(sch | side << 4 | set << 5);
      open_cmd <= 0; cur_stk <= kind[0]; pos_stk <= kind[1]; fd <= fv[0];
      repeat (10) @(posedge clk);
      wb(1, A_CTRL, ctrl, r);
      wb(1, A_MASK, 32'(m), r);
      wb(1, A_IRQ, 32'h7, r);
      trg <= 6'(1 << src);
      open_cmd <= 1;
      repeat (3) @(posedge clk);
      trg <= 0;
      repeat (4 * (set + 4)) @(posedge clk);
      check(32'(bkp), 0);
      repeat (4 * set + 32) @(posedge clk);
      e = exp_trip(sch, kind, fv, side);
      check(32'(bkp), 32'(e));
      check(32'(lock), 32'(e));
      check(32'(irq), 32'(e & m[0]));
      wb(0, A_CTRL, 0, r); check(32'(r[C_ACK]), 32'(e));
      wb(1, A_CTRL, ctrl | 32'h80, r);
      wb(1, A_IRQ, 32'h7, r);
      repeat (3) @(posedge clk);
      check(32'({bkp, lock, irq}), 0);
    end
    wb(1, A_CTRL, 32'h01, r);
    wb(1, A_MASK, 32'h2, r);
    open_cmd <= 0; cur_stk <= 0; pos_stk <= 0; fd <= 0;
    repeat (10) @(posedge clk);
    trg <= 6'h08;
    open_cmd <= 1;
    repeat (20) @(posedge clk);
    check(32'({rej, irq}), 32'h3);
    // breaker recloses with trigger still high: no second run
    open_cmd <= 0;
    repeat (60) @(posedge clk);
    check(32'({rej, bkp}), 32'h2);
    trg <= 0;
    repeat (6) @(posedge clk);
    check(32'(rej), 0);
    wb(0, A_STAT, 0, r); check(32'(r[3:0]), 32'h1);
    wb(1, A_IRQ, 32'h7, r);
    repeat (3) @(posedge clk);
    check(32'(irq), 0);
    report_and_stop();
  end
endmodule
